// ===== qdl_device.sv
// Device end: serial shift register, input and output registers
`timescale 1ns/1ps
// Overview of operation
// - Floating strobe selects two-wire, high three-wire
// - Three-wire samples data on falling clock edges
// - Strobe low, clock high loads addressed channel
// - Update low copies all input to outputs
// - Shift register exit bit drives chain output
// - Start is data fall then clock fall
// - Start loads zero into eleven bit register
// - Host keeps data stable while clock high; three-wire frames move it with clock high at first bit and strobe end
// - Stop: data low, clock rises, data rises
// - Select high, select low, code MSB first
// - Select bits pick channel A through D
// - Cascade uses one start, zero separators, stop
// - Every stop takes local shift register frame
// - Update may be tied low or strobe; three-wire loads need update high, so tied low works in two-wire only
// - Host holds update until stop detected
// - Two-wire host leaves strobe floating; a driven high selects three-wire
// - Host stretches timing for cascaded devices; qdl_host keeps one fixed LINK_HALF_CYC half period
// - Idle two-wire lines stay high
module qdl_device (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  qdl_link_if.device LINK,
  output logic [7:0] CODE_A,
  output logic [7:0] CODE_B,
  output logic [7:0] CODE_C,
  output logic [7:0] CODE_D,
  output logic FRAME_ACTIVE
);
  logic sck, sda, stb_n, upd_n, at_supply, sck_q, sda_q;
  logic [qdl_pkg::SHIFT_BITS-1:0] shift;
  logic [7:0] in_reg [qdl_pkg::NUM_CH];
  logic [7:0] out_reg [qdl_pkg::NUM_CH];
  logic in_frame, arming, two_wire;
  logic sck_fall, sda_fall, sda_rise, load_3w, stop_2w;
  logic start_shift, data_shift;
  logic [1:0] sel;

  // Every pin passes two flops; reset values match the idle high lines
  qdl_sync2 #(
    .RESET_VAL(1'b1)
  ) sync_sck (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .d(LINK.serial_clock_in),
    .q(sck)
  );
  qdl_sync2 #(
    .RESET_VAL(1'b1)
  ) sync_sda (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .d(LINK.serial_data_in),
    .q(sda)
  );
  qdl_sync2 #(
    .RESET_VAL(1'b1)
  ) sync_stb (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .d(LINK.strobe_pin),
    .q(stb_n)
  );
  qdl_sync2 #(
    .RESET_VAL(1'b1)
  ) sync_upd (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .d(LINK.update_outputs_n),
    .q(upd_n)
  );
  qdl_sync2 #(
    .RESET_VAL(1'b1)
  ) sync_mode (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .d(LINK.strobe_at_supply),
    .q(at_supply)
  );

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      sck_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (CE) begin
      sck_q <= sck;
      sda_q <= sda;
    end
  end

  assign sck_fall = sck_q & ~sck;
  assign sda_fall = sda_q & ~sda;
  assign sda_rise = ~sda_q & sda;

  // A floating strobe sits at the supply, a driven high only at logic level, so three-wire mode is
  // seen before the first frame bit shifts; the host changes mode only when idle.
  assign two_wire = at_supply;

  // Start detect: data falls while clock high arms, clock fall while data low starts
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      arming <= 1'b0;
      in_frame <= 1'b0;
    end else if (CE && two_wire) begin
      if (sda_fall && sck && !in_frame) begin
        arming <= 1'b1;
      end else if (sda && arming) begin
        arming <= 1'b0;
      end else if (arming && sck_fall && !sda) begin
        arming <= 1'b0;
        in_frame <= 1'b1;
      end else if (stop_2w) begin
        in_frame <= 1'b0;
      end
    end
  end

  // Stop: data rises while clock high inside a frame
  assign stop_2w = two_wire && in_frame && sda_rise && sck;
  assign load_3w = !two_wire && !stb_n && sck && upd_n;

  // Shift on falling clock; frame order select high first down to code lsb
  assign start_shift = two_wire && arming && sck_fall && !sda;
  assign data_shift = sck_fall && (!two_wire || in_frame);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      shift <= qdl_pkg::SHIFT_RESET;
    end else if (CE) begin
      if (start_shift) begin
        shift <= {shift[qdl_pkg::SHIFT_BITS-2:0], 1'b0};
      end else if (data_shift) begin
        shift <= {shift[qdl_pkg::SHIFT_BITS-2:0], sda};
      end
    end
  end

  assign sel = {shift[qdl_pkg::SEL_HI_POS], shift[qdl_pkg::SEL_LO_POS]};

  // Input registers take the code byte of the addressed channel
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < qdl_pkg::NUM_CH; i++) begin
        in_reg[i] <= qdl_pkg::CODE_RESET;
      end
    end else if (CE && (load_3w || stop_2w)) begin
      in_reg[sel] <= shift[qdl_pkg::CODE_MSB_POS:0];
    end
  end

  // Update is level sensitive: outputs follow inputs while it is low
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < qdl_pkg::NUM_CH; i++) begin
        out_reg[i] <= qdl_pkg::CODE_RESET;
      end
    end else if (CE && !upd_n) begin
      for (int i = 0; i < qdl_pkg::NUM_CH; i++) begin
        out_reg[i] <= in_reg[i];
      end
    end
  end

  // Chain out moves together with each shift, while the link clock is still low, so a
  // chained device never sees its data change with the clock high; mode changes leave it
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LINK.serial_chain_out <= 1'b0;
      CODE_A <= qdl_pkg::CODE_RESET;
      CODE_B <= qdl_pkg::CODE_RESET;
      CODE_C <= qdl_pkg::CODE_RESET;
      CODE_D <= qdl_pkg::CODE_RESET;
      FRAME_ACTIVE <= 1'b0;
    end else if (CE) begin
      if (start_shift || data_shift) begin
        LINK.serial_chain_out <= two_wire ? shift[qdl_pkg::SHIFT_BITS-2]
                                          : shift[qdl_pkg::FRAME_BITS-2];
      end
      CODE_A <= out_reg[0];
      CODE_B <= out_reg[1];
      CODE_C <= out_reg[2];
      CODE_D <= out_reg[3];
      FRAME_ACTIVE <= in_frame;
    end
  end
endmodule // qdl_device

// Two-flop synchroniser for a pin that comes from outside the clock domain
module qdl_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic [1:0] stage;

  // Only the second flop is read, so a metastable first stage never reaches logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage <= {2{RESET_VAL}};
    end else if (ce) begin
      stage <= {stage[0], d};
    end
  end

  assign q = stage[1];
endmodule // qdl_sync2

// ===== qdl_host.sv
// Host end: sends frames over the three-wire or two-wire link
`timescale 1ns/1ps
module qdl_host (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  qdl_link_if.host LINK,
  input wire logic START,
  input wire logic TWO_WIRE,
  input wire logic [1:0] CHANNEL,
  input wire logic [7:0] CODE,
  input wire logic UPDATE,
  output logic BUSY,
  output logic DONE,
  output logic CHAIN_IN
);
  typedef enum logic [2:0] {
    QDL_IDLE, QDL_START, QDL_BITS, QDL_STOP, QDL_STROBE, QDL_UPDATE
  } qdl_hstate_t;
  qdl_hstate_t state;
  logic [qdl_pkg::FRAME_BITS-1:0] frame;
  logic [3:0] bit_cnt;
  logic [3:0] tick;
  logic [1:0] phase;
  logic mode2, do_update;
  logic [1:0] chain_sync;
  logic tick_done;

  assign tick_done = (tick == 4'(qdl_pkg::LINK_HALF_CYC - 1));

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      chain_sync <= 2'h0;
      CHAIN_IN <= 1'b0;
    end else if (CE) begin
      chain_sync <= {chain_sync[0], LINK.serial_chain_out};
      CHAIN_IN <= chain_sync[1];
    end
  end

  // Clock divider phases: each phase lasts half a link period
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tick <= 4'h0;
    end else if (CE) begin
      tick <= (state == QDL_IDLE || tick_done) ? 4'h0 : tick + 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= QDL_IDLE;
      frame <= '0;
      bit_cnt <= 4'h0;
      phase <= 2'h0;
      mode2 <= 1'b0;
      do_update <= 1'b0;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      LINK.serial_clock_in <= 1'b1;
      LINK.serial_data_in <= 1'b1;
      LINK.transfer_strobe_n <= 1'b1;
      LINK.transfer_strobe_oe <= 1'b0;
      LINK.update_outputs_n <= 1'b1;
    end else if (CE) begin
      DONE <= 1'b0;
      case (state)
        QDL_IDLE: begin
          if (START) begin
            frame <= {CHANNEL, CODE};
            mode2 <= TWO_WIRE;
            do_update <= UPDATE;
            bit_cnt <= 4'h0;
            phase <= 2'h0;
            BUSY <= 1'b1;
            LINK.transfer_strobe_oe <= !TWO_WIRE;
            state <= TWO_WIRE ? QDL_START : QDL_BITS;
          end
        end
        QDL_START: if (tick_done) begin
          phase <= phase + 2'h1;
          if (phase == 2'h0) begin
            LINK.serial_data_in <= 1'b0;
          end else begin
            LINK.serial_clock_in <= 1'b0;
            phase <= 2'h0;
            state <= QDL_BITS;
          end
        end
        QDL_BITS: if (tick_done) begin
          // Data changes while clock low, except the first bit of a three-wire frame
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              LINK.serial_data_in <= frame[qdl_pkg::FRAME_BITS-1];
              frame <= {frame[qdl_pkg::FRAME_BITS-2:0], 1'b0};
            end
            2'h1: LINK.serial_clock_in <= 1'b1;
            default: begin
              LINK.serial_clock_in <= 1'b0;
              phase <= 2'h0;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'(qdl_pkg::FRAME_BITS - 1)) begin
                state <= mode2 ? QDL_STOP : QDL_STROBE;
              end
            end
          endcase
        end
        QDL_STOP: if (tick_done) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: LINK.serial_data_in <= 1'b0;
            2'h1: LINK.serial_clock_in <= 1'b1;
            default: begin
              LINK.serial_data_in <= 1'b1;
              phase <= 2'h0;
              state <= do_update ? QDL_UPDATE : QDL_STROBE;
            end
          endcase
        end
        QDL_STROBE: if (tick_done) begin
          // Half period after last edge covers the strobe delay
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              if (!mode2) begin
                LINK.serial_clock_in <= 1'b1;
                LINK.transfer_strobe_n <= 1'b0;
              end
            end
            default: begin
              LINK.transfer_strobe_n <= 1'b1;
              phase <= 2'h0;
              state <= (do_update && !mode2) ? QDL_UPDATE : QDL_IDLE;
              DONE <= !(do_update && !mode2);
              BUSY <= do_update && !mode2;
              // Strobe stays driven high, keeping three-wire use until a two-wire start;
              // data returns high so that start sees a falling data edge
              LINK.serial_data_in <= 1'b1;
            end
          endcase
        end
        QDL_UPDATE: if (tick_done) begin
          // Update only after stop (two-wire) or the strobe pulse (three-wire) has been seen by the device
          phase <= phase + 2'h1;
          case (phase)
            2'h0: LINK.update_outputs_n <= 1'b0;
            default: begin
              LINK.update_outputs_n <= 1'b1;
              phase <= 2'h0;
              BUSY <= 1'b0;
              DONE <= 1'b1;
              state <= QDL_IDLE;
            end
          endcase
        end
        default: state <= QDL_IDLE;
      endcase
    end
  end
endmodule // qdl_host

// ===== qdl_link_if.sv
// Link wires between the host and the quad converter loader
`timescale 1ns/1ps
interface qdl_link_if;
  logic serial_clock_in;
  logic serial_data_in;
  logic transfer_strobe_n;
  logic transfer_strobe_oe;
  logic update_outputs_n;
  logic serial_chain_out;
  // Floating strobe pin is pulled up
  logic strobe_pin;
  assign strobe_pin = transfer_strobe_oe ? transfer_strobe_n : 1'b1;
  // Level sense: a floating strobe rests at the supply, above a driven logic high
  logic strobe_at_supply;
  assign strobe_at_supply = !transfer_strobe_oe;
  modport device (
    input serial_clock_in,
    input serial_data_in,
    input strobe_pin,
    input strobe_at_supply,
    input update_outputs_n,
    output serial_chain_out
  );
  modport host (
    output serial_clock_in,
    output serial_data_in,
    output transfer_strobe_n,
    output transfer_strobe_oe,
    output update_outputs_n,
    input serial_chain_out
  );
endinterface

// ===== qdl_link_sva.sv
// Protocol checks on the link between host and converter loader
`timescale 1ns/1ps
module qdl_link_sva (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic transfer_strobe_n,
  input wire logic transfer_strobe_oe,
  input wire logic update_outputs_n,
  input wire logic serial_chain_out,
  input wire logic strobe_pin
);
  logic d_q;
  logic c_q;
  logic in_frame;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      d_q <= 1'b1;
      c_q <= 1'b1;
    end else begin
      d_q <= serial_data_in;
      c_q <= serial_clock_in;
    end
  end
  // Frame tracking mirrors start and stop so strobe and update can be judged
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      in_frame <= 1'b0;
    end else if (!transfer_strobe_oe && c_q && serial_clock_in && d_q && !serial_data_in) begin
      in_frame <= 1'b1;
    end else if (c_q && serial_clock_in && !d_q && serial_data_in) begin
      in_frame <= 1'b0;
    end
  end
  sequence start_s;
    !transfer_strobe_oe && $fell(serial_data_in) && serial_clock_in;
  endsequence
  sequence stop_s;
    !transfer_strobe_oe && $rose(serial_data_in) && serial_clock_in;
  endsequence
  pull_up_a: assert property (!transfer_strobe_oe |-> strobe_pin)
    else $error("strobe pin not pulled high");
  start_order_a: assert property (start_s |-> ##[1:8] ($fell(serial_clock_in) && !serial_data_in))
    else $error("start not followed by clock fall");
  idle_after_stop_a: assert property (stop_s |=> (serial_data_in && serial_clock_in)[*3])
    else $error("link not idle high after stop");
  data_hold_a: assert property (in_frame && $rose(serial_clock_in) |=> $stable(serial_data_in)[*2])
    else $error("data moved while clock high");
  strobe_load_a: assert property ($fell(strobe_pin) |->
    (transfer_strobe_oe && serial_clock_in && !strobe_pin)[*4])
    else $error("strobe pulse malformed");
  update_width_a: assert property ($fell(update_outputs_n) |->
    (!update_outputs_n)[*2] ##[1:8] update_outputs_n)
    else $error("update pulse malformed");
  update_apart_a: assert property (transfer_strobe_oe && !transfer_strobe_n |-> update_outputs_n)
    else $error("update low during strobe");
  update_after_stop_a: assert property ($fell(update_outputs_n) |-> !in_frame)
    else $error("update inside frame");
  strobe_free_a: assert property (in_frame |-> !transfer_strobe_oe)
    else $error("strobe driven in frame");
  chain_timing_a: assert property ($changed(serial_chain_out) |-> !serial_clock_in)
    else $error("chain output moved with clock high");
endmodule // qdl_link_sva

// ===== qdl_pkg.sv
// Shared constants and types for the quad converter serial loader
package qdl_pkg;
  localparam int FRAME_BITS = 10;
  localparam int SHIFT_BITS = 11;
  localparam int CODE_BITS = 8;
  localparam int NUM_CH = 4;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [10:0] SHIFT_RESET = 11'h000;
  localparam int SEL_HI_POS = 9;
  localparam int SEL_LO_POS = 8;
  localparam int CODE_MSB_POS = 7;
  // Host link timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_HALF_NS = 400;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_DELAY_NS = 150;
  localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPDATE_WIDTH_NS = 150;
  localparam int UPDATE_WIDTH_CYC = (UPDATE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Device side settle time; qdl_device does not use it, stop counts at once
  localparam int SETTLE_CYC = 2;
  typedef enum logic [1:0] {QDL_MODE_3W, QDL_MODE_2W} qdl_mode_t;
endpackage

// ===== tb.sv
// Testbench joining host and converter loader across the link
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rstn;
  logic ce;
  logic start;
  logic two_wire;
  logic [1:0] channel;
  logic [7:0] code;
  logic update;
  logic busy;
  logic done;
  logic chain_in;
  logic frame_active;
  logic [7:0] outs [4];
  logic [7:0] in_exp [4];
  logic [7:0] out_exp [4];
  logic [7:0] tbl [4] = '{8'h80, 8'h01, 8'hC3, 8'h7E};
  int failures;
  int total_checks;
  int cycles;
  qdl_link_if link();
  qdl_host qdl_host_inst (.CLK(clk), .RSTN(rstn), .CE(ce), .LINK(link), .START(start),
    .TWO_WIRE(two_wire), .CHANNEL(channel), .CODE(code), .UPDATE(update), .BUSY(busy),
    .DONE(done), .CHAIN_IN(chain_in));
  qdl_device qdl_device_inst (.CLK(clk), .RSTN(rstn), .CE(ce), .LINK(link),
    .CODE_A(outs[0]), .CODE_B(outs[1]), .CODE_C(outs[2]), .CODE_D(outs[3]),
    .FRAME_ACTIVE(frame_active));
  qdl_link_sva qdl_link_sva_inst (.CLK(clk), .RSTN(rstn),
    .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in),
    .transfer_strobe_n(link.transfer_strobe_n), .transfer_strobe_oe(link.transfer_strobe_oe),
    .update_outputs_n(link.update_outputs_n), .serial_chain_out(link.serial_chain_out),
    .strobe_pin(link.strobe_pin));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task conclude;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task check_all;
    for (int i = 0; i < 4; i++)
      check("code", outs[i], out_exp[i]);
  endtask
  task do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      in_exp[i] = 8'h00;
      out_exp[i] = 8'h00;
    end
    repeat (2) @(negedge clk);
    check_all();
  endtask
  // One whole frame; expectations follow the channel map and update rule
  task automatic send(input logic tw, input logic [1:0] ch, input logic [7:0] cd,
    input logic upd);
    int n;
    @(posedge clk);
    two_wire <= tw;
    channel <= ch;
    code <= cd;
    update <= upd;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(negedge clk);
    check("frame", {7'h00, frame_active}, {7'h00, tw});
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("done", {7'h00, done}, 8'h01);
    in_exp[ch] = cd;
    if (upd)
      out_exp = in_exp;
    repeat (10) @(negedge clk);
    check("frame", {7'h00, frame_active}, 8'h00);
    check("chain", {7'h00, chain_in}, {7'h00, tw ? 1'b0 : ch[1]});
    check("busy", {7'h00, busy}, 8'h00);
    check_all();
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    start = 1'b0;
    two_wire = 1'b0;
    channel = 2'h0;
    code = 8'h00;
    update = 1'b0;
    do_reset();
    send(1'b1, 2'h0, 8'hA5, 1'b1);
    send(1'b1, 2'h1, 8'h3C, 1'b1);
    send(1'b1, 2'h2, 8'hFF, 1'b1);
    send(1'b1, 2'h3, 8'h00, 1'b1);
    // Held load must stay invisible until the next update copies all channels
    send(1'b1, 2'h1, 8'h81, 1'b0);
    send(1'b1, 2'h2, 8'h5A, 1'b1);
    do_reset();
    for (int c = 0; c < 4; c++)
      send(1'b0, 2'(c), tbl[c], c == 3);
    send(1'b0, 2'h0, 8'hFF, 1'b1);
    conclude();
  end
endmodule // tb
